// ==== verif/smc_bus_model.sv ====
// far-side party on the bus: one master framing scl and sda
// assumes open-drain lines with pull-ups, so both idle high
module smc_bus_model
(
   input wire logic frame_i,
   input wire logic stall_i,
   input wire logic stop_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      forever
      begin
         wait (frame_i);
         #100 sda_o = 1'b0;
         // clock only runs inside a frame, 320 ns period
         while (frame_i)
         begin
            #160 scl_o = 1'b0;
            wait (!stall_i);
            #160 scl_o = 1'b1;
         end
         if (stop_i)
            #100 sda_o = 1'b1;
         else
         begin
            // sda released under scl low: no stop, bus left busy
            #80 scl_o = 1'b0;
            #80 sda_o = 1'b1;
            #80 scl_o = 1'b1;
         end
      end
   end
endmodule : smc_bus_model

// ==== verif/testbench.sv ====
// bench for the smbus configuration block
// assumes the far-side model on scl and sda, core clock 25 mhz
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, wr, split, sev, mev, frame, stall, stop, ce;
   logic scl, sda, act, busy, hold, tick, rhi, rlo, sirq, mirq;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] ovf;
   int err_count, num_checks, cycles;
   smc_config i_smc_config (.core_clk_i(clk), .resetn_i(rstn), .ce_i(ce),
      .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
      .sfr_rdata_o(rdata), .scl_i(scl), .sda_i(sda), .t0_ovf_i(ovf[0]),
      .t1_ovf_i(ovf[1]), .t2h_ovf_i(ovf[2]), .t2l_ovf_i(ovf[3]),
      .t3_split_i(split), .slave_event_i(sev), .master_event_i(mev),
      .smb_active_o(act), .busy_o(busy), .hold_ext_o(hold),
      .bit_tick_o(tick), .t3_high_reload_o(rhi), .t3_low_reload_o(rlo),
      .slave_irq_o(sirq), .master_irq_o(mirq));
   smc_bus_model i_smc_bus_model (.frame_i(frame), .stall_i(stall),
      .stop_i(stop), .scl_o(scl), .sda_o(sda));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h want %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      cyc(1);
      chk(rdata, e);
   endtask : rd_reg
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // ----------------------------------------------------------------
   // clock, hang guard, tests
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      // whole run needs well under a thousand cycles
      if (cycles == 3000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   initial
   begin
      int s;
      int k;
      {rstn, wr, split, sev, mev, frame, stall} = 7'h00;
      stop = 1'b1;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      ovf = 4'h0;
      repeat (12) @(posedge clk);
      #2 rstn = 1'b1;
      rd_reg(8'hc1, 8'h00);
      wr_reg(8'hc1, 8'hff);
      rd_reg(8'hc1, 8'hdf);
      chk({6'h00, act, hold}, 8'h03);
      wr_reg(8'hc2, 8'h00);
      rd_reg(8'hc2, 8'h00);
      rd_reg(8'hc1, 8'hdf);
      wr_reg(8'hc1, 8'h00);
      chk({6'h00, act, hold}, 8'h00);
      $display("test registers done");
      for (s = 0; s < 4; s++)
      begin
         wr_reg(8'hc1, 8'h80 | 8'(s));
         for (k = 0; k < 4; k++)
         begin
            ovf = 4'h1 << k;
            cyc(1);
            chk({7'h00, tick}, {7'h00, k == s});
            ovf = 4'h0;
            cyc(1);
         end
      end
      $display("test clock sources done");
      wr_reg(8'hc1, 8'h88);
      chk({6'h00, rhi, rlo}, 8'h03);
      split = 1'b1;
      cyc(1);
      chk({6'h00, rhi, rlo}, 8'h02);
      stall = 1'b1;
      frame = 1'b1;
      cyc(14);
      chk({7'h00, busy}, 8'h01);
      chk({6'h00, rhi, rlo}, 8'h00);
      rd_reg(8'hc1, 8'ha8);
      sev = 1'b1;
      mev = 1'b1;
      cyc(1);
      chk({6'h00, sirq, mirq}, 8'h03);
      wr_reg(8'hc1, 8'hc8);
      chk({6'h00, sirq, mirq}, 8'h01);
      {sev, mev, stall, split, frame} = 5'h00;
      cyc(20);
      chk({7'h00, busy}, 8'h00);
      $display("test busy and reload done");
      wr_reg(8'hc1, 8'h84);
      stop = 1'b0;
      frame = 1'b1;
      cyc(8);
      frame = 1'b0;
      cyc(20);
      chk({7'h00, busy}, 8'h01);
      repeat (10)
      begin
         ovf = 4'h1;
         cyc(1);
         ovf = 4'h0;
         cyc(3);
      end
      chk({7'h00, busy}, 8'h01);
      ovf = 4'h1;
      cyc(1);
      ovf = 4'h0;
      cyc(4);
      chk({7'h00, busy}, 8'h00);
      frame = 1'b1;
      cyc(12);
      wr_reg(8'hc1, 8'h00);
      cyc(1);
      chk({7'h00, busy}, 8'h00);
      $display("test free timeout done");
      // clock enable low: the write must not land
      ce = 1'b0;
      wr_reg(8'hc1, 8'h90);
      chk({6'h00, act, hold}, 8'h00);
      ce = 1'b1;
      cyc(1);
      wr_reg(8'hc1, 8'h90);
      chk({6'h00, act, hold}, 8'h03);
      // mid-run reset returns every field to zero
      rstn = 1'b0;
      cyc(2);
      rstn = 1'b1;
      rd_reg(8'hc1, 8'h00);
      chk({6'h00, act, hold}, 8'h00);
      $display("test enable and reset done");
      report_and_stop();
   end
endmodule : testbench

// ==== verilog/smc_config.sv ====
// smbus configuration register, busy tracking and timeout control
// assumes sfr bus and timer overflows on core_clk_i, pins asynchronous
`include "smc_defs.svh"
// Operation
// - the enable bit turns the interface on and makes it watch the lines.
// - slave inhibit blocks slave interrupts but leaves master ones alone.
// - busy is set by a transfer and cleared by stop, bus free timeout or the enable bit going low.
// - the hold extension bit selects lengthened sda setup and hold.
// - with clock low timeout on, the timer reloads while scl is high.
// - in split mode only the upper timer half is held in reload.
// - bus free timeout frees the bus after over ten source periods high.
// - a two bit field picks timer 0, 1, 2 high or 2 low overflow.
module smc_config
   import smc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic t0_ovf_i,
   input wire logic t1_ovf_i,
   input wire logic t2h_ovf_i,
   input wire logic t2l_ovf_i,
   input wire logic t3_split_i,
   input wire logic slave_event_i,
   input wire logic master_event_i,
   output logic smb_active_o,
   output logic busy_o,
   output logic hold_ext_o,
   output logic bit_tick_o,
   output logic t3_high_reload_o,
   output logic t3_low_reload_o,
   output logic slave_irq_o,
   output logic master_irq_o
);
   // ----------------------------------------------------------------
   // line synchronisers
   // ----------------------------------------------------------------
   smc_line_if scl ();
   smc_line_if sda ();

   smc_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .pin_i(scl_i),
      .line(scl.src)
   );

   smc_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .pin_i(sda_i),
      .line(sda.src)
   );

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic cfg_hit;
   logic en;
   smc_bus_state_t state_reg;
   smc_bus_state_t state_next;

   assign cfg_hit = sfr_addr_i == `SMC_CFG_ADDR;
   assign en = cfg_reg[`SMC_BIT_EN];

   always_comb
   begin
      cfg_next = cfg_reg;
      if (sfr_wr_i && cfg_hit)
      begin
         cfg_next = sfr_wdata_i;
         cfg_next[`SMC_BIT_BUSY] = 1'b0;
      end
      rdata_next = 8'h00;
      if (cfg_hit)
      begin
         rdata_next = cfg_reg;
         rdata_next[`SMC_BIT_BUSY] = state_reg == SMC_BUSY;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cfg_reg <= `SMC_CFG_RESET;
         rdata_reg <= 8'h00;
      end
      else if (ce_i)
      begin
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // bit rate source and bus free timeout
   // ----------------------------------------------------------------
   logic src_tick;
   logic [3:0] free_cnt_reg;
   logic [3:0] free_cnt_next;
   logic free_hit;
   logic tick_reg;
   logic start_seen;
   logic stop_seen;

   always_comb
   begin
      case (smc_src_sel_t'(cfg_reg[`SMC_SRC_HI:`SMC_SRC_LO]))
         `SMC_SRC_T0: src_tick = t0_ovf_i;
         `SMC_SRC_T1: src_tick = t1_ovf_i;
         `SMC_SRC_T2H: src_tick = t2h_ovf_i;
         `SMC_SRC_T2L: src_tick = t2l_ovf_i;
         default: src_tick = 1'b0;
      endcase
   end

   // counts ticks only while both lines sit high; saturates one past ten
   always_comb
   begin
      free_cnt_next = free_cnt_reg;
      if (!en || !cfg_reg[`SMC_BIT_FTE] || !scl.lvl || !sda.lvl)
         free_cnt_next = 4'h0;
      else if (src_tick && free_cnt_reg <= `SMC_FREE_PERIODS)
         free_cnt_next = free_cnt_reg + 4'h1;
   end

   // lines must still be high now, so a start in the same cycle wins
   assign free_hit = free_cnt_reg > `SMC_FREE_PERIODS
      && scl.lvl && sda.lvl;
   assign start_seen = en && sda.fall && scl.lvl;
   assign stop_seen = en && sda.rise && scl.lvl;

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         free_cnt_reg <= 4'h0;
         tick_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         free_cnt_reg <= free_cnt_next;
         tick_reg <= src_tick;
      end
   end

   // ----------------------------------------------------------------
   // busy tracking
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SMC_IDLE:
            if (start_seen)
               state_next = SMC_BUSY;
         SMC_BUSY:
            if (!en || stop_seen || free_hit)
               state_next = SMC_IDLE;
         default: state_next = SMC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state_reg <= SMC_IDLE;
      else if (ce_i)
         state_reg <= state_next;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic low_to_hold;
   assign low_to_hold = en && cfg_reg[`SMC_BIT_TOE] && scl.lvl;

   assign sfr_rdata_o = rdata_reg;
   assign smb_active_o = en;
   assign busy_o = state_reg == SMC_BUSY;
   assign hold_ext_o = cfg_reg[`SMC_BIT_HOLD];
   assign bit_tick_o = tick_reg;
   assign t3_high_reload_o = low_to_hold;
   assign t3_low_reload_o = low_to_hold && !t3_split_i;
   // slave side drops out entirely, master path untouched
   assign slave_irq_o = en && slave_event_i
      && !cfg_reg[`SMC_BIT_SLV_INHIBIT];
   assign master_irq_o = en && master_event_i;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   chk_disabled_idle: assert property (
      (ce_i && !en) |=> !busy_o)
      else $error("busy while disabled");
   chk_slave_inhibit: assert property (
      cfg_reg[`SMC_BIT_SLV_INHIBIT] |-> !slave_irq_o)
      else $error("slave irq while inhibited");
   chk_master_pass: assert property (
      (en && master_event_i) |-> master_irq_o)
      else $error("master irq lost");
   chk_busy_start: assert property (
      (ce_i && start_seen) |=> busy_o)
      else $error("busy not set by start");
   chk_busy_stop: assert property (
      (ce_i && busy_o && stop_seen) |=> !busy_o)
      else $error("busy not cleared by stop");
   chk_hold_ext: assert property (
      (ce_i && sfr_wr_i && cfg_hit) |=>
         hold_ext_o == $past(sfr_wdata_i[`SMC_BIT_HOLD]))
      else $error("hold extension not written");
   chk_reload_scl: assert property (
      (!scl.lvl) |-> !t3_high_reload_o && !t3_low_reload_o)
      else $error("timer held while scl low");
   chk_split_low: assert property (
      (t3_split_i && t3_high_reload_o) |-> !t3_low_reload_o)
      else $error("low half held in split mode");
   chk_free_timeout: assert property (
      (ce_i && busy_o && free_hit) |=> !busy_o)
      else $error("busy kept after free timeout");
   chk_src_select: assert property (
      (ce_i && cfg_reg[1:0] == `SMC_SRC_T1 && t1_ovf_i) |=> bit_tick_o)
      else $error("timer 1 tick not selected");
   chk_busy_ro: assert property (
      (ce_i && sfr_wr_i && cfg_hit) |=> !cfg_reg[`SMC_BIT_BUSY])
      else $error("busy bit stored by write");
endmodule : smc_config

// ==== verilog/smc_defs.svh ====
// constants for the smbus configuration block
// assumes an 8-bit sfr bus and a 25 mhz core clock
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
// ----------------------------------------------------------------
// register address and reset
// ----------------------------------------------------------------
`define SMC_CFG_ADDR 8'hc1
`define SMC_CFG_RESET 8'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMC_BIT_EN 7
`define SMC_BIT_SLV_INHIBIT 6
`define SMC_BIT_BUSY 5
`define SMC_BIT_HOLD 4
`define SMC_BIT_TOE 3
`define SMC_BIT_FTE 2
`define SMC_SRC_HI 1
`define SMC_SRC_LO 0
// ----------------------------------------------------------------
// clock source encodings and bus free count
// ----------------------------------------------------------------
`define SMC_SRC_T0 2'h0
`define SMC_SRC_T1 2'h1
`define SMC_SRC_T2H 2'h2
`define SMC_SRC_T2L 2'h3
`define SMC_FREE_PERIODS 4'ha
`endif

// ==== verilog/smc_line_if.sv ====
// synchronised bus line with its edges
// assumes one producer and one consumer on the core clock
interface smc_line_if;
   logic lvl;
   logic rise;
   logic fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : smc_line_if

// ==== verilog/smc_pkg.sv ====
// types for the smbus configuration block
// assumes nothing beyond the defs header
package smc_pkg;
   typedef enum logic {SMC_IDLE, SMC_BUSY} smc_bus_state_t;
   typedef logic [1:0] smc_src_sel_t;
endpackage : smc_pkg

// ==== verilog/smc_sync.sv ====
// two-flop synchroniser with edge detect for one bus line
// assumes the pin is asynchronous to core_clk_i
module smc_sync
   import smc_pkg::*;
#(
   parameter logic RST_VAL = 1'b1
)(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic pin_i,
   smc_line_if.src line
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic s1_next;
   logic s2_next;
   logic s3_next;

   always_comb
   begin
      s1_next = pin_i;
      s2_next = s1_reg;
      s3_next = s2_reg;
   end

   // idle lines are high, so reset high avoids a false edge
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end
      else if (ce_i)
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end

   assign line.lvl = s2_reg;
   assign line.rise = s2_reg & ~s3_reg;
   assign line.fall = ~s2_reg & s3_reg;
endmodule : smc_sync
